// ---- hw/link_regs_pkg.sv ----
package link_regs_pkg;

    // config space offsets (byte addresses)
    localparam logic [11:0] link_capabilities_off = 12'h0ec;
    localparam logic [11:0] link_ctl_off = 12'h0f0;

    // link capabilities field positions
    localparam int cap_speed_lsb = 0;
    localparam int cap_width_lsb = 4;
    localparam int cap_aspm_lsb = 10;
    localparam int cap_l0s_lsb = 12;
    localparam int cap_l1_lsb = 15;
    localparam int cap_sdown_bit = 19;
    localparam int cap_dllla_bit = 20;
    localparam int cap_port_lsb = 24;

    // link capabilities fixed codes and reset values
    localparam logic [3:0] speed_2g5 = 4'h1;
    localparam logic [5:0] width_x1 = 6'h01;
    localparam logic [1:0] aspm_supp_rst = 2'h3;
    localparam logic [2:0] l0s_lat_rst = 3'h1;
    localparam logic [2:0] l1_lat_rst = 3'h6;
    localparam logic [2:0] l1_lat_none = 3'h7;
    localparam logic [7:0] port_num_rst = 8'h00;

    // link control field positions and reset values
    localparam int ctl_aspm_lsb = 0;
    localparam int ctl_rcb_bit = 3;
    localparam int ctl_disable_bit = 4;
    localparam int ctl_retrain_bit = 5;
    localparam int ctl_cclk_bit = 6;
    localparam int ctl_xsync_bit = 7;
    localparam logic [1:0] aspm_ctl_rst = 2'h0;

    // nvm init words and field positions inside them
    localparam logic [7:0] nvm_lat_word = 8'h18;
    localparam logic [7:0] nvm_aspm_word = 8'h1a;
    localparam int nvm_l0s_cc_lsb = 0;
    localparam int nvm_l0s_sep_lsb = 3;
    localparam int nvm_l1_lsb = 6;
    localparam int nvm_aspm_lsb = 0;

    // configuration access request from the config-space decoder
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    // read answer
    typedef struct packed {
        logic valid;
        logic hit;
        logic [31:0] rdata;
    } cfg_rsp_t;

    // one word handed over by the nvm reader
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [15:0] data;
    } nvm_word_t;

    // values loaded from nvm
    typedef struct packed {
        logic [1:0] aspm_supp;
        logic [2:0] l0s_cc;
        logic [2:0] l0s_sep;
        logic [2:0] l1_lat;
    } nvm_cfg_t;

    // link control as seen by the power manager
    typedef struct packed {
        logic [1:0] aspm;
        logic xsync;
    } pm_ctl_t;

    // ordered-set requests to the transmitter on l0s exit
    typedef struct packed {
        logic fts;
        logic ext_fts;
        logic ts1;
    } exit_req_t;

endpackage

// ---- hw/nvm_init_capture.sv ----
`timescale 1ns/10ps
module nvm_init_capture (
    input wire logic clock,
    input wire logic rst_b,
    input link_regs_pkg::nvm_word_t nvm_in,
    output link_regs_pkg::nvm_cfg_t cfg
);

    link_regs_pkg::nvm_cfg_t cfg_ff;
    link_regs_pkg::nvm_cfg_t nxt_cfg;

    // pick fields out of the two init words as they stream past
    always_comb begin
        nxt_cfg = cfg_ff;
        if (nvm_in.valid && nvm_in.addr == link_regs_pkg::nvm_aspm_word) begin
            nxt_cfg.aspm_supp = nvm_in.data[link_regs_pkg::nvm_aspm_lsb +: 2];
        end
        if (nvm_in.valid && nvm_in.addr == link_regs_pkg::nvm_lat_word) begin
            nxt_cfg.l0s_cc = nvm_in.data[link_regs_pkg::nvm_l0s_cc_lsb +: 3];
            nxt_cfg.l0s_sep = nvm_in.data[link_regs_pkg::nvm_l0s_sep_lsb +: 3];
            nxt_cfg.l1_lat = nvm_in.data[link_regs_pkg::nvm_l1_lsb +: 3];
        end
    end

    // each default holds until the nvm reader delivers the init word that carries its field
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff.aspm_supp <= link_regs_pkg::aspm_supp_rst;
            cfg_ff.l0s_cc <= link_regs_pkg::l0s_lat_rst;
            cfg_ff.l0s_sep <= link_regs_pkg::l0s_lat_rst;
            cfg_ff.l1_lat <= link_regs_pkg::l1_lat_rst;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign cfg = cfg_ff;

endmodule

// ---- hw/aspm_entry_ctl.sv ----
`timescale 1ns/10ps
module aspm_entry_ctl (
    input wire logic clock,
    input wire logic rst_b,
    input link_regs_pkg::pm_ctl_t ctl,
    input wire logic [1:0] aspm_supp,
    input wire logic [2:0] l1_lat,
    input wire logic link_idle,
    input wire logic link_wake,
    output logic in_l0s,
    output logic in_l1,
    output link_regs_pkg::exit_req_t exit_req
);

    typedef enum logic [1:0] {st_l0, st_l0s, st_l1} pm_state_t;

    pm_state_t state_ff;
    pm_state_t nxt_state;
    link_regs_pkg::exit_req_t exit_ff;
    link_regs_pkg::exit_req_t nxt_exit;
    logic in_l0s_ff;
    logic nxt_in_l0s;
    logic in_l1_ff;
    logic nxt_in_l1;
    logic l0s_ok;
    logic l1_ok;

    // entry needs both software enable and advertised support
    assign l0s_ok = ctl.aspm[0] & aspm_supp[0];
    assign l1_ok = ctl.aspm[1] & aspm_supp[1] & (l1_lat != link_regs_pkg::l1_lat_none);

    // l1 preferred when allowed; wake wins over a fresh idle
    always_comb begin
        nxt_state = state_ff;
        nxt_exit = '0;
        case (state_ff)
            st_l0: begin
                if (link_idle && !link_wake && l1_ok) begin
                    nxt_state = st_l1;
                end else if (link_idle && !link_wake && l0s_ok) begin
                    nxt_state = st_l0s;
                end
            end
            st_l0s: begin
                if (link_wake || !l0s_ok) begin
                    nxt_state = st_l0;
                    nxt_exit.fts = 1'b1;
                    nxt_exit.ext_fts = ctl.xsync;
                    nxt_exit.ts1 = ctl.xsync;
                end
            end
            st_l1: begin
                if (link_wake || !l1_ok) begin
                    nxt_state = st_l0;
                end
            end
            default: begin
                nxt_state = st_l0;
            end
        endcase
        // state flags decoded ahead so the ports come straight from flops
        nxt_in_l0s = (nxt_state == st_l0s);
        nxt_in_l1 = (nxt_state == st_l1);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= st_l0;
            exit_ff <= '0;
            in_l0s_ff <= 1'b0;
            in_l1_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            exit_ff <= nxt_exit;
            in_l0s_ff <= nxt_in_l0s;
            in_l1_ff <= nxt_in_l1;
        end
    end

    assign in_l0s = in_l0s_ff;
    assign in_l1 = in_l1_ff;
    assign exit_req = exit_ff;

endmodule

// ---- hw/pcie_link_capabilities_control_regs.sv ----
`timescale 1ns/10ps
module pcie_link_capabilities_control_regs (
    input wire logic clock,
    input wire logic rst_b,
    input link_regs_pkg::cfg_req_t cfg_req,
    output link_regs_pkg::cfg_rsp_t cfg_rsp,
    input link_regs_pkg::nvm_word_t nvm_in,
    input wire logic port_num_load,
    input wire logic [7:0] port_num_in,
    input wire logic link_idle,
    input wire logic link_wake,
    output logic in_l0s,
    output logic in_l1,
    output link_regs_pkg::exit_req_t exit_req,
    output logic [2:0] l0s_exit_lat,
    output logic [2:0] l1_exit_lat,
    output logic read_comp_128
);

    link_regs_pkg::nvm_cfg_t nvm_cfg;
    link_regs_pkg::pm_ctl_t pm_ctl;
    link_regs_pkg::cfg_rsp_t rsp_ff;
    link_regs_pkg::cfg_rsp_t nxt_rsp;

    logic [1:0] aspm_ctl_ff;
    logic [1:0] nxt_aspm_ctl;
    logic rcb_ff;
    logic nxt_rcb;
    logic cclk_ff;
    logic nxt_cclk;
    logic xsync_ff;
    logic nxt_xsync;
    logic [7:0] port_num_ff;
    logic [7:0] nxt_port_num;
    logic [2:0] l0s_lat_ff;
    logic [2:0] nxt_l0s_lat;
    logic [2:0] l1_lat_ff;
    logic [2:0] nxt_l1_lat;

    logic [2:0] l0s_sel;
    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic ctl_wr;

    // init values from the nvm words
    nvm_init_capture i_nvm_init_capture (
        .clock(clock),
        .rst_b(rst_b),
        .nvm_in(nvm_in),
        .cfg(nvm_cfg)
    );

    // latency in force depends on the clocking of the two link ends
    assign l0s_sel = cclk_ff ? nvm_cfg.l0s_cc : nvm_cfg.l0s_sep;

    // capabilities image; unlisted bits stay zero
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[link_regs_pkg::cap_speed_lsb +: 4] = link_regs_pkg::speed_2g5;
        cap_word[link_regs_pkg::cap_width_lsb +: 6] = link_regs_pkg::width_x1;
        cap_word[link_regs_pkg::cap_aspm_lsb +: 2] = nvm_cfg.aspm_supp;
        cap_word[link_regs_pkg::cap_l0s_lsb +: 3] = l0s_sel;
        cap_word[link_regs_pkg::cap_l1_lsb +: 3] = nvm_cfg.l1_lat;
        cap_word[link_regs_pkg::cap_sdown_bit] = 1'b0;
        cap_word[link_regs_pkg::cap_dllla_bit] = 1'b0;
        cap_word[link_regs_pkg::cap_port_lsb +: 8] = port_num_ff;
    end

    // control image; link status half above is not this block's, reads zero
    always_comb begin
        ctl_word = 32'h0000_0000;
        ctl_word[link_regs_pkg::ctl_aspm_lsb +: 2] = aspm_ctl_ff;
        ctl_word[link_regs_pkg::ctl_rcb_bit] = rcb_ff;
        ctl_word[link_regs_pkg::ctl_disable_bit] = 1'b0;
        ctl_word[link_regs_pkg::ctl_retrain_bit] = 1'b0;
        ctl_word[link_regs_pkg::ctl_cclk_bit] = cclk_ff;
        ctl_word[link_regs_pkg::ctl_xsync_bit] = xsync_ff;
    end

    // only byte lane 0 of link control carries writable bits
    assign ctl_wr = cfg_req.wr && cfg_req.be[0]
        && (cfg_req.addr == link_regs_pkg::link_ctl_off);

    // writable control bits; capability writes fall through untouched
    always_comb begin
        nxt_aspm_ctl = aspm_ctl_ff;
        nxt_rcb = rcb_ff;
        nxt_cclk = cclk_ff;
        nxt_xsync = xsync_ff;
        if (ctl_wr) begin
            nxt_aspm_ctl = cfg_req.wdata[link_regs_pkg::ctl_aspm_lsb +: 2];
            nxt_rcb = cfg_req.wdata[link_regs_pkg::ctl_rcb_bit];
            nxt_cclk = cfg_req.wdata[link_regs_pkg::ctl_cclk_bit];
            nxt_xsync = cfg_req.wdata[link_regs_pkg::ctl_xsync_bit];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            aspm_ctl_ff <= link_regs_pkg::aspm_ctl_rst;
            rcb_ff <= 1'b0;
            cclk_ff <= 1'b0;
            xsync_ff <= 1'b0;
        end else begin
            aspm_ctl_ff <= nxt_aspm_ctl;
            rcb_ff <= nxt_rcb;
            cclk_ff <= nxt_cclk;
            xsync_ff <= nxt_xsync;
        end
    end

    // port number comes from training, never from software
    always_comb begin
        nxt_port_num = port_num_ff;
        if (port_num_load) begin
            nxt_port_num = port_num_in;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            port_num_ff <= link_regs_pkg::port_num_rst;
        end else begin
            port_num_ff <= nxt_port_num;
        end
    end

    // read answer one cycle after the request; other offsets read zero
    always_comb begin
        nxt_rsp = '0;
        if (cfg_req.rd) begin
            nxt_rsp.valid = 1'b1;
            if (cfg_req.addr == link_regs_pkg::link_capabilities_off) begin
                nxt_rsp.hit = 1'b1;
                nxt_rsp.rdata = cap_word;
            end else if (cfg_req.addr == link_regs_pkg::link_ctl_off) begin
                nxt_rsp.hit = 1'b1;
                nxt_rsp.rdata = ctl_word;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff <= nxt_rsp;
        end
    end

    // latency outputs registered so the ports come from flops
    always_comb begin
        nxt_l0s_lat = l0s_sel;
        nxt_l1_lat = nvm_cfg.l1_lat;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            l0s_lat_ff <= link_regs_pkg::l0s_lat_rst;
            l1_lat_ff <= link_regs_pkg::l1_lat_rst;
        end else begin
            l0s_lat_ff <= nxt_l0s_lat;
            l1_lat_ff <= nxt_l1_lat;
        end
    end

    // power state entry follows the programmed enables
    assign pm_ctl.aspm = aspm_ctl_ff;
    assign pm_ctl.xsync = xsync_ff;

    aspm_entry_ctl i_aspm_entry_ctl (
        .clock(clock),
        .rst_b(rst_b),
        .ctl(pm_ctl),
        .aspm_supp(nvm_cfg.aspm_supp),
        .l1_lat(nvm_cfg.l1_lat),
        .link_idle(link_idle),
        .link_wake(link_wake),
        .in_l0s(in_l0s),
        .in_l1(in_l1),
        .exit_req(exit_req)
    );

    assign cfg_rsp = rsp_ff;
    assign l0s_exit_lat = l0s_lat_ff;
    assign l1_exit_lat = l1_lat_ff;
    assign read_comp_128 = rcb_ff;

endmodule

// ---- tb/link_regs_monitor.sv ----
`timescale 1ns/10ps
module link_regs_monitor (
    input wire logic clock,
    input wire logic rst_b,
    input link_regs_pkg::cfg_req_t cfg_req,
    input link_regs_pkg::cfg_rsp_t cfg_rsp,
    input wire logic port_num_load,
    input wire logic [7:0] port_num_in,
    input wire logic link_idle,
    input wire logic link_wake,
    input wire logic in_l0s,
    input wire logic in_l1,
    input link_regs_pkg::exit_req_t exit_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // reads of the two mapped words
    logic rd_cap;
    logic rd_ctl;
    assign rd_cap = cfg_req.rd && cfg_req.addr == 12'h0ec;
    assign rd_ctl = cfg_req.rd && cfg_req.addr == 12'h0f0;
    speed_code_a: assert property (rd_cap |=> cfg_rsp.rdata[3:0] == 4'h1)
        else $error("max speed field wrong");
    width_code_a: assert property (rd_cap |=> cfg_rsp.rdata[9:4] == 6'h01)
        else $error("max width field wrong");
    cap_zero_a: assert property (rd_cap |=> cfg_rsp.rdata[23:18] == 6'h00)
        else $error("capability zero bits set");
    ctl_zero_a: assert property (rd_ctl |=>
        cfg_rsp.rdata[31:8] == 24'h0 && cfg_rsp.rdata[5:4] == 2'h0 && !cfg_rsp.rdata[2])
        else $error("link control fixed bits set");
    port_load_a: assert property (port_num_load ##1 (rd_cap && !port_num_load)
        |=> cfg_rsp.rdata[31:24] == $past(port_num_in, 2))
        else $error("port number not loaded");
    rsp_pulse_a: assert property (1'b1 |=> cfg_rsp.valid == $past(cfg_req.rd))
        else $error("read answer timing wrong");
    miss_zero_a: assert property (cfg_req.rd && !rd_cap && !rd_ctl
        |=> !cfg_rsp.hit && cfg_rsp.rdata == 32'h0)
        else $error("unmapped read not zero");
    one_state_a: assert property (!(in_l0s && in_l1))
        else $error("both low power states");
    busy_stay_a: assert property (!in_l0s && !in_l1 && !link_idle
        |=> !in_l0s && !in_l1)
        else $error("low power without idle");
    wake_exit_a: assert property (in_l0s && link_wake |=> !in_l0s && exit_req.fts)
        else $error("l0s exit missing");
    fts_pulse_a: assert property (exit_req.fts |->
        (!in_l0s && $past(in_l0s)) ##1 !exit_req.fts)
        else $error("fts request misplaced");
    ext_both_a: assert property (exit_req.ext_fts |-> exit_req.fts && exit_req.ts1)
        else $error("extended sync incomplete");
    cover property (rd_cap ##1 cfg_rsp.hit);
    cover property (in_l1);
    cover property (exit_req.ext_fts);
endmodule
bind pcie_link_capabilities_control_regs link_regs_monitor i_link_regs_monitor (.clock(clock),
    .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .port_num_load(port_num_load),
    .port_num_in(port_num_in), .link_idle(link_idle), .link_wake(link_wake),
    .in_l0s(in_l0s), .in_l1(in_l1), .exit_req(exit_req));

// ---- tb/test_pcie_link_capabilities_control_regs.sv ----
`timescale 1ns/10ps
module test_pcie_link_capabilities_control_regs;
    logic clock;
    logic rst_b;
    link_regs_pkg::cfg_req_t req;
    link_regs_pkg::cfg_rsp_t rsp;
    link_regs_pkg::nvm_word_t nvm;
    link_regs_pkg::exit_req_t xr;
    logic pl;
    logic [7:0] pn;
    logic idle;
    logic wake;
    logic l0s;
    logic l1;
    logic [2:0] l0l;
    logic [2:0] l1l;
    logic rcb;
    logic hit_s;
    logic [31:0] d;
    int checks;
    int n_fail;

    pcie_link_capabilities_control_regs i_pcie_link_capabilities_control_regs (.clock(clock), .rst_b(rst_b),
        .cfg_req(req), .cfg_rsp(rsp), .nvm_in(nvm), .port_num_load(pl), .port_num_in(pn),
        .link_idle(idle), .link_wake(wake), .in_l0s(l0s), .in_l1(l1), .exit_req(xr),
        .l0s_exit_lat(l0l), .l1_exit_lat(l1l), .read_comp_128(rcb));

    // free-running core clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // read: answer sampled at the negedge that drops the request
    task automatic rd(input logic [11:0] a);
        @(negedge clock);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clock);
        req.rd = 1'b0;
        d = rsp.rdata;
        hit_s = rsp.hit;
        chk("valid", 32'h1, 32'(rsp.valid));
    endtask

    task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] v);
        @(negedge clock);
        req.wr = 1'b1;
        req.addr = a;
        req.be = b;
        req.wdata = v;
        @(negedge clock);
        req.wr = 1'b0;
    endtask

    task automatic nv(input logic [7:0] a, input logic [15:0] v);
        @(negedge clock);
        nvm = {1'b1, a, v};
        @(negedge clock);
        nvm.valid = 1'b0;
    endtask

    task automatic t_defaults();
        rd(12'h0ec);
        chk("cap reset", 32'h00031c11, d);
        chk("cap hit", 32'h1, 32'(hit_s));
        rd(12'h0f0);
        chk("ctl reset", 32'h0, d);
        chk("l0s lat", 32'h1, 32'(l0l));
        chk("l1 lat", 32'h6, 32'(l1l));
    endtask

    // each control mode; pass 4 repeats l0s entry with extended sync off
    task automatic t_aspm();
        logic [1:0] mm;
        logic xs;
        for (int m = 0; m < 5; m++) begin
            mm = (m == 4) ? 2'h1 : m[1:0];
            xs = (m < 4) && mm[0];
            wr(12'h0f0, 4'h1, {24'h0, xs, 5'h0, mm});
            @(negedge clock);
            idle = 1'b1;
            repeat (2) @(negedge clock);
            chk("in l0s", 32'(mm == 2'h1), 32'(l0s));
            chk("in l1", 32'(mm[1]), 32'(l1));
            wake = 1'b1;
            @(negedge clock);
            chk("woken", 32'h0, 32'(l0s | l1));
            chk("fts", 32'(mm == 2'h1), 32'(xr.fts));
            chk("ext fts", 32'(mm == 2'h1 && xs), 32'(xr.ext_fts));
            chk("ts1", 32'(mm == 2'h1 && xs), 32'(xr.ts1));
            idle = 1'b0;
            wake = 1'b0;
        end
    endtask

    task automatic t_nvm();
        nv(8'h18, 16'h012a);
        nv(8'h1a, 16'h0001);
        rd(12'h0ec);
        chk("cap separate", 32'h00025411, d);
        wr(12'h0f0, 4'h1, 32'h40);
        rd(12'h0ec);
        chk("cap common", 32'h00022411, d);
        chk("l0s lat", 32'h2, 32'(l0l));
        // l1 code 111 must block l1 even when enabled
        nv(8'h18, 16'h01ea);
        nv(8'h1a, 16'h0003);
        wr(12'h0f0, 4'h1, 32'h02);
        @(negedge clock);
        idle = 1'b1;
        repeat (3) @(negedge clock);
        chk("l1 blocked", 32'h0, 32'(l1));
        chk("l1 lat", 32'h7, 32'(l1l));
        idle = 1'b0;
    endtask

    task automatic t_ro();
        wr(12'h0ec, 4'hf, 32'hffffffff);
        wr(12'h0f0, 4'he, 32'hffffffff);
        rd(12'h0f0);
        chk("ctl no be0", 32'h02, d);
        wr(12'h0f0, 4'hf, 32'hffffffff);
        rd(12'h0f0);
        chk("ctl ones", 32'hcb, d);
        chk("rcb", 32'h1, 32'(rcb));
        rd(12'h0ec);
        chk("cap ro", 32'h0003ac11, d);
        rd(12'h0f4);
        chk("miss data", 32'h0, d);
        chk("miss hit", 32'h0, 32'(hit_s));
        wr(12'h0f0, 4'hf, 32'h0);
    endtask

    // read issued in the cycle right after training loads the port
    task automatic t_port();
        @(negedge clock);
        pl = 1'b1;
        pn = 8'ha5;
        @(negedge clock);
        pl = 1'b0;
        req.rd = 1'b1;
        req.addr = 12'h0ec;
        @(negedge clock);
        req.rd = 1'b0;
        chk("port", 32'ha503dc11, rsp.rdata);
    endtask

    task automatic report_and_stop();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // whole run is under a hundred cycles
    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        req = '0;
        nvm = '0;
        pl = 1'b0;
        pn = 8'h00;
        idle = 1'b0;
        wake = 1'b0;
        rst_b = 1'b0;
        checks = 0;
        n_fail = 0;
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        t_defaults();
        t_aspm();
        t_nvm();
        t_ro();
        t_port();
        report_and_stop();
    end
endmodule
